// ==== inc/pmm_defines.svh ====
// Constants and functional notes of the program/data memory map block
`ifndef PMM_DEFINES_SVH
`define PMM_DEFINES_SVH
`define PMM_ADDR_ABUF 14'h3ff3
`define PMM_ADDR_DATA_MEMORY_WAIT_STATE_CONTROL 14'h3ffe
`define PMM_ADDR_SYSCTL 14'h3fff
`define PMM_AHB_ABUF 16'hffcc
`define PMM_AHB_DATA_MEMORY_WAIT_STATE_CONTROL 16'hfff8
`define PMM_AHB_SYSCTL 16'hfffc
`define PMM_AHB_STATUS 16'h0000
`define PMM_ROMEN_BIT 15
`define PMM_CLKGATE_BIT 14
`define PMM_WAIT_RST 3'h7
`define PMM_PRAM_LOW 14'h0000
`define PMM_PRAM_HIGH 14'h3800
`define PMM_ROM_BASE 14'h0800
`define PMM_EXT_BASE 14'h1000
`define PMM_VEC_END 14'h005f
`define PMM_DRAM_BASE 14'h3800
`define PMM_PERI_BASE 14'h2000
`define PMM_CORE_BASE 14'h3c00
`define PMM_BLK_MASK 14'h3c00
`define PMM_PROM_MASK 14'h3800
`define PMM_STRAP_SETTLE 3'h5
`endif

// ==== inc/pmm_pkg.sv ====
// Types of the program/data memory map block
package pmm_pkg;
   typedef enum logic [2:0] {PMM_PRAM, PMM_PROM, PMM_DRAM, PMM_PERI, PMM_CORE, PMM_EXT} pmm_target_t;
   typedef enum logic [1:0] {PMM_X_IDLE, PMM_X_WAIT, PMM_X_DONE} pmm_xstate_t;
endpackage

// ==== src/pmm_memory_map.sv ====
// Program and data memory map decode, wait states and clock output control
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "pmm_defines.svh"
module pmm_memory_map
   import pmm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [15:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic map_select_strap,
   input wire logic boot_select_strap,
   input wire logic core_req,
   input wire logic core_is_data,
   input wire logic core_write,
   input wire logic [13:0] core_addr,
   output logic core_ack,
   output logic [2:0] core_target,
   output logic [13:0] boot_start_addr,
   output logic boot_load_en,
   output logic monitor_avail,
   output logic periph_clk_en,
   output logic instruction_clock_output,
   output logic [13:0] ext_addr,
   output logic ext_addr_oe,
   output logic ext_data_oe,
   output logic ext_pmsel_n,
   output logic ext_dmsel_n,
   output logic ext_rd_n,
   output logic ext_wr_n
);
   ////////////////////////////////////////////////////////////////////////////
   // Strap capture
   logic [2:0] map_sync_r;
   logic [2:0] boot_sync_r;
   logic map_r;
   logic boot_r;
   logic strap_done_r;
   // Three-stage synchronisers on the strap pins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         map_sync_r <= 3'h0;
         boot_sync_r <= 3'h0;
      end
      else
      begin
         map_sync_r <= {map_sync_r[1:0], map_select_strap};
         boot_sync_r <= {boot_sync_r[1:0], boot_select_strap};
      end
   end
   // Filtered strap levels, taken when stages two and three agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         map_r <= 1'b0;
         boot_r <= 1'b0;
      end
      else
      begin
         if (map_sync_r[2] == map_sync_r[1])
            map_r <= map_sync_r[2];
         if (boot_sync_r[2] == boot_sync_r[1])
            boot_r <= boot_sync_r[2];
      end
   end
   // Loads the strap-dependent ROM enable only once the filtered levels are valid
   logic [2:0] settle_r;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         settle_r <= 3'h0;
         strap_done_r <= 1'b0;
      end
      else
      begin
         if (settle_r != `PMM_STRAP_SETTLE)
            settle_r <= settle_r + 3'h1;
         strap_done_r <= (settle_r == `PMM_STRAP_SETTLE);
      end
   end
   wire strap_load = (settle_r == `PMM_STRAP_SETTLE) && !strap_done_r;
   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic internal_rom_select_r;
   logic clock_output_gate_r;
   logic [13:0] abuf_other_r;
   logic [2:0] data_wait_count_a_r;
   logic [2:0] data_wait_count_b_r;
   logic [2:0] data_wait_count_c_r;
   logic [2:0] data_wait_count_d_r;
   logic [2:0] data_wait_count_e_r;
   logic [2:0] program_wait_count_r;
   // AHB address phase capture
   logic wr_pend_r;
   logic rd_pend_r;
   logic rd_fill_r;
   logic [15:0] addr_r;
   wire bus_go = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 16'h0000;
      end
      else if (hready)
      begin
         wr_pend_r <= bus_go && hwrite;
         rd_pend_r <= bus_go && !hwrite;
         addr_r <= haddr;
      end
   end
   // Read data phase gets one wait state while the read word is registered
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rd_fill_r <= 1'b0;
      else
         rd_fill_r <= rd_pend_r && !rd_fill_r;
   end
   wire wr_abuf = wr_pend_r && (addr_r == `PMM_AHB_ABUF);
   wire wr_memw = wr_pend_r && (addr_r == `PMM_AHB_DATA_MEMORY_WAIT_STATE_CONTROL);
   wire wr_sysc = wr_pend_r && (addr_r == `PMM_AHB_SYSCTL);
   // ROM enable: reset clear, loaded from straps, then software written
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         internal_rom_select_r <= 1'b0;
      else if (strap_load)
         internal_rom_select_r <= map_r & boot_r;
      else if (wr_memw)
         internal_rom_select_r <= hwdata[`PMM_ROMEN_BIT];
   end
   // five data wait fields, all reset to seven
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_wait_count_a_r <= `PMM_WAIT_RST;
         data_wait_count_b_r <= `PMM_WAIT_RST;
         data_wait_count_c_r <= `PMM_WAIT_RST;
         data_wait_count_d_r <= `PMM_WAIT_RST;
         data_wait_count_e_r <= `PMM_WAIT_RST;
      end
      else if (wr_memw)
      begin
         data_wait_count_a_r <= hwdata[2:0];
         data_wait_count_b_r <= hwdata[5:3];
         data_wait_count_c_r <= hwdata[8:6];
         data_wait_count_d_r <= hwdata[11:9];
         data_wait_count_e_r <= hwdata[14:12];
      end
   end
   // program wait field of the system control word, reset to seven
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         program_wait_count_r <= `PMM_WAIT_RST;
      else if (wr_sysc)
         program_wait_count_r <= hwdata[2:0];
   end
   // autobuffer word with the clock output gate bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clock_output_gate_r <= 1'b0;
         abuf_other_r <= 14'h0000;
      end
      else if (wr_abuf)
      begin
         clock_output_gate_r <= hwdata[`PMM_CLKGATE_BIT];
         abuf_other_r <= hwdata[13:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Read mux, one wait state on reads, always OKAY
   logic [15:0] rd_word;
   pmm_xstate_t xstate_r;
   always_comb
   begin
      rd_word = 16'h0000;
      unique case (addr_r)
         `PMM_AHB_ABUF: rd_word = {1'b0, clock_output_gate_r, abuf_other_r};
         `PMM_AHB_DATA_MEMORY_WAIT_STATE_CONTROL: rd_word = {internal_rom_select_r, data_wait_count_e_r, data_wait_count_d_r,
            data_wait_count_c_r, data_wait_count_b_r, data_wait_count_a_r};
         `PMM_AHB_SYSCTL: rd_word = {13'h0000, program_wait_count_r};
         `PMM_AHB_STATUS: rd_word = {12'h000, xstate_r == PMM_X_WAIT, monitor_avail, boot_r, map_r};
         default: rd_word = 16'h0000;
      endcase
   end
   // Read data register, filled in the first data phase cycle of a read
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (bus_go && !hwrite)
         hrdata <= 32'h0000_0000;
      else if (rd_pend_r && !rd_fill_r)
         hrdata <= {16'h0000, rd_word};
   end
   assign hreadyout = !(rd_pend_r && !rd_fill_r);
   assign hresp = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   pmm_target_t tgt;
   wire [13:0] pram_base = (map_r && !boot_r) ? `PMM_PRAM_HIGH : `PMM_PRAM_LOW;
   always_comb
   begin
      // anything not decoded below goes external
      tgt = PMM_EXT;
      if (core_is_data)
      begin
         if ((core_addr & `PMM_BLK_MASK) == `PMM_DRAM_BASE)
            tgt = PMM_DRAM;
         else if ((core_addr & `PMM_BLK_MASK) == `PMM_PERI_BASE)
            tgt = PMM_PERI;
         else if ((core_addr & `PMM_BLK_MASK) == `PMM_CORE_BASE)
            tgt = PMM_CORE;
      end
      // program RAM at the bottom, or at the top when relocated
      else if ((core_addr & `PMM_PROM_MASK) == pram_base)
         tgt = PMM_PRAM;
      // ROM range follows the enable bit
      else if ((core_addr & `PMM_PROM_MASK) == `PMM_ROM_BASE)
         tgt = internal_rom_select_r ? PMM_PROM : PMM_EXT;
   end
   // start address and boot behaviour per strap mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         boot_start_addr <= 14'h0000;
         boot_load_en <= 1'b0;
      end
      else
      begin
         boot_start_addr <= (map_r && boot_r) ? `PMM_ROM_BASE : `PMM_PRAM_LOW;
         boot_load_en <= !(map_r && !boot_r);
      end
   end
   assign monitor_avail = internal_rom_select_r;
   ////////////////////////////////////////////////////////////////////////////
   // External access sequencing
   // no interrupt logic here: priority and masking live in the core
   logic tm_start;
   logic tm_busy;
   logic tm_done;
   logic cur_data_r;
   logic cur_write_r;
   logic [2:0] wsel;
   // Data wait field chosen by address quarter, with field e for the top eighth
   always_comb
   begin
      unique case (core_addr[13:12])
         2'h0: wsel = data_wait_count_a_r;
         2'h1: wsel = data_wait_count_b_r;
         2'h2: wsel = data_wait_count_c_r;
         default: wsel = data_wait_count_d_r;
      endcase
      if (core_addr[13:11] == 3'h7)
         wsel = data_wait_count_e_r;
   end
   // A request still held during its own acknowledge is not taken again
   assign tm_start = core_req && !core_ack && (tgt == PMM_EXT) && (xstate_r == PMM_X_IDLE);
   pmm_wait_timer u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(tm_start),
      .waits(core_is_data ? wsel : program_wait_count_r),
      .busy(tm_busy),
      .done(tm_done)
   );
   // Access state and latched attributes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         xstate_r <= PMM_X_IDLE;
         cur_data_r <= 1'b0;
         cur_write_r <= 1'b0;
         ext_addr <= 14'h0000;
         core_target <= 3'h0;
      end
      else
      begin
         unique case (xstate_r)
            PMM_X_IDLE:
               if (core_req && !core_ack)
               begin
                  core_target <= tgt;
                  if (tgt == PMM_EXT)
                  begin
                     xstate_r <= PMM_X_WAIT;
                     cur_data_r <= core_is_data;
                     cur_write_r <= core_write;
                     ext_addr <= core_addr;
                  end
               end
            PMM_X_WAIT:
               if (tm_done)
                  xstate_r <= PMM_X_DONE;
            PMM_X_DONE:
               xstate_r <= PMM_X_IDLE;
         endcase
      end
   end
   // Internal hits answer next cycle, external after waits
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         core_ack <= 1'b0;
      else
         core_ack <= (xstate_r == PMM_X_IDLE && core_req && !core_ack && tgt != PMM_EXT)
            || (xstate_r == PMM_X_WAIT && tm_done);
   end
   wire ext_act = (xstate_r == PMM_X_WAIT) && tm_busy;
   assign ext_pmsel_n = !(ext_act && !cur_data_r);
   assign ext_dmsel_n = !(ext_act && cur_data_r);
   assign ext_rd_n = !(ext_act && !cur_write_r);
   assign ext_wr_n = !(ext_act && cur_write_r);
   assign ext_addr_oe = ext_act;
   assign ext_data_oe = ext_act && cur_write_r;
   ////////////////////////////////////////////////////////////////////////////
   // Instruction clock output
   // pin toggles each cycle; the gate holds it low and stops peripherals
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         instruction_clock_output <= 1'b0;
         periph_clk_en <= 1'b0;
      end
      else
      begin
         instruction_clock_output <= !instruction_clock_output && !clock_output_gate_r;
         periph_clk_en <= !clock_output_gate_r;
      end
   end
endmodule

// ==== src/pmm_wait_timer.sv ====
// Wait state counter for one external access
`timescale 1ns/10ps
module pmm_wait_timer
   import pmm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [2:0] waits,
   output logic busy,
   output logic done
);
   logic [2:0] cnt_r;
   logic run_r;

   // Counts the requested wait states, then pulses done
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r <= 3'h0;
         run_r <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            cnt_r <= waits;
            run_r <= 1'b1;
         end
         else if (run_r)
         begin
            if (cnt_r == 3'h0)
            begin
               run_r <= 1'b0;
               done <= 1'b1;
            end
            else
               cnt_r <= cnt_r - 3'h1;
         end
      end
   end

   assign busy = run_r | start;
endmodule

// ==== verification/pmm_ext_mem_model.sv ====
// External memory model that watches the select lines and the write strobe
`timescale 1ns/10ps
module pmm_ext_mem_model
(
   input wire logic hclk,
   input wire logic clr,
   input wire logic ext_pmsel_n,
   input wire logic ext_dmsel_n,
   input wire logic ext_wr_n,
   output logic [7:0] sel_cycles,
   output logic wr_seen
);
   // Count selected cycles of one access and note any write strobe
   always_ff @(posedge hclk)
   begin
      if (clr)
      begin
         sel_cycles <= 8'h00;
         wr_seen <= 1'b0;
      end
      else
      begin
         if (!ext_pmsel_n || !ext_dmsel_n)
            sel_cycles <= sel_cycles + 8'h01;
         if (!ext_wr_n)
            wr_seen <= 1'b1;
      end
   end
endmodule

// ==== verification/pmm_memory_map_asserts.sv ====
// Port assertions of the memory map block
`timescale 1ns/10ps
module pmm_memory_map_asserts
   import pmm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic map_select_strap,
   input wire logic boot_select_strap,
   input wire logic core_ack,
   input wire logic [13:0] boot_start_addr,
   input wire logic boot_load_en,
   input wire logic periph_clk_en,
   input wire logic instruction_clock_output,
   input wire logic ext_addr_oe,
   input wire logic ext_pmsel_n,
   input wire logic ext_dmsel_n,
   input wire logic ext_rd_n
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_sel_drives_bus: assert property ((!ext_pmsel_n || !ext_dmsel_n) |-> ext_addr_oe)
      else $error("select low with address bus off");
   a_ext_ack_bound: assert property ($fell(ext_rd_n) |-> ##[1:10] core_ack)
      else $error("no acknowledge after external read");
   a_ack_one_cycle: assert property (core_ack |=> !core_ack)
      else $error("acknowledge longer than one cycle");
   a_clk_toggles: assert property (periph_clk_en && $past(periph_clk_en)
      |-> instruction_clock_output != $past(instruction_clock_output))
      else $error("clock output not toggling");
   a_clk_gated_low: assert property (!periph_clk_en && !$past(periph_clk_en) |-> !instruction_clock_output)
      else $error("clock output running while gated");
   a_boot_standalone: assert property ((map_select_strap && boot_select_strap) [*8]
      |-> boot_start_addr == 14'h0800 && boot_load_en)
      else $error("standalone start wrong");
   a_boot_relocated: assert property ((map_select_strap && !boot_select_strap) [*8]
      |-> boot_start_addr == 14'h0000 && !boot_load_en)
      else $error("relocated map start wrong");
   a_boot_bytewide: assert property ((!map_select_strap && !boot_select_strap) [*8]
      |-> boot_start_addr == 14'h0000 && boot_load_en)
      else $error("byte boot start wrong");
endmodule
bind pmm_memory_map pmm_memory_map_asserts pmm_memory_map_asserts_inst (.hclk, .hresetn, .map_select_strap,
   .boot_select_strap, .core_ack, .boot_start_addr, .boot_load_en, .periph_clk_en, .instruction_clock_output,
   .ext_addr_oe, .ext_pmsel_n, .ext_dmsel_n, .ext_rd_n);

// ==== verification/pmm_memory_map_tb.sv ====
// Self-checking bench for the memory map block
`timescale 1ns/10ps
module pmm_memory_map_tb
   import pmm_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b1;
   logic map_select_strap = 1'b0, boot_select_strap = 1'b0;
   logic core_req = 1'b0, core_is_data = 1'b0, core_write = 1'b0;
   logic [15:0] haddr = 16'h0000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, core_target;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, r;
   logic [13:0] core_addr = 14'h0000, ext_addr, boot_start_addr;
   logic [7:0] sel_cycles;
   logic hreadyout, hresp, core_ack, boot_load_en, monitor_avail, periph_clk_en, instruction_clock_output;
   logic ext_addr_oe, ext_data_oe, ext_pmsel_n, ext_dmsel_n, ext_rd_n, ext_wr_n, wr_seen;
   int mismatches = 0, checks_done = 0;
   pmm_memory_map pmm_memory_map_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .map_select_strap, .boot_select_strap, .core_req,
      .core_is_data, .core_write, .core_addr, .core_ack, .core_target, .boot_start_addr, .boot_load_en,
      .monitor_avail, .periph_clk_en, .instruction_clock_output, .ext_addr, .ext_addr_oe, .ext_data_oe,
      .ext_pmsel_n, .ext_dmsel_n, .ext_rd_n, .ext_wr_n);
   pmm_ext_mem_model pmm_ext_mem_model_inst (.hclk, .clr, .ext_pmsel_n, .ext_dmsel_n, .ext_wr_n, .sel_cycles,
      .wr_seen);
   always #4 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL %s exp %h got %h", name, exp, got);
      end
   endtask
   // Bounded wait for the bus ready
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            mismatches++;
            stop_test();
         end
         @(posedge hclk);
      end
   endtask
   // One single-word bus transfer
   task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   // Core access with target and select-cycle checks
   task automatic core(input logic d, input logic w, input logic [13:0] a, input pmm_target_t t, input int ws);
      int n;
      n = 0;
      clr <= 1'b1;
      core_req <= 1'b1;
      core_is_data <= d;
      core_write <= w;
      core_addr <= a;
      @(posedge hclk);
      clr <= 1'b0;
      while (core_ack !== 1'b1)
      begin
         n++;
         if (n > 40)
         begin
            mismatches++;
            stop_test();
         end
         @(posedge hclk);
      end
      core_req <= 1'b0;
      chk("target", 32'(t), 32'(core_target));
      chk("select cycles", 32'(ws + 1), 32'(sel_cycles));
      chk("write strobe", 32'(w && ws >= 0), 32'(wr_seen));
      if (ws >= 0)
         chk("ext addr", 32'(a), 32'(ext_addr));
      repeat (2) @(posedge hclk);
   endtask
   // Reset with strap levels held from reset onward
   task automatic do_reset(input logic m, input logic b);
      hresetn <= 1'b0;
      map_select_strap <= m;
      boot_select_strap <= b;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      do_reset(1'b0, 1'b0);
      ahb(1'b0, 16'hfff8, 32'h0000_0000, r);
      chk("wait ctl", 32'h0000_7fff, r);
      ahb(1'b0, 16'hfffc, 32'h0000_0000, r);
      chk("prog waits", 32'h0000_0007, {29'h0, r[2:0]});
      ahb(1'b0, 16'h0040, 32'h0000_0000, r);
      chk("unmapped", 32'h0000_0000, r);
      chk("start addr", 32'h0000_0000, 32'(boot_start_addr));
      chk("monitor", 32'h0000_0000, 32'(monitor_avail));
      $display("test 1 done");
      ahb(1'b1, 16'hfffc, 32'h0000_0003, r);
      ahb(1'b1, 16'hfff8, 32'h0000_460a, r);
      ahb(1'b0, 16'hfff8, 32'h0000_0000, r);
      chk("wait ctl", 32'h0000_460a, r);
      core(1'b0, 1'b0, 14'h0000, PMM_PRAM, -1);
      core(1'b0, 1'b0, 14'h005f, PMM_PRAM, -1);
      core(1'b0, 1'b0, 14'h0800, PMM_EXT, 3);
      core(1'b0, 1'b0, 14'h1000, PMM_EXT, 3);
      core(1'b0, 1'b1, 14'h3800, PMM_EXT, 3);
      core(1'b1, 1'b0, 14'h3bff, PMM_DRAM, -1);
      core(1'b1, 1'b1, 14'h2000, PMM_PERI, -1);
      core(1'b1, 1'b0, 14'h3c00, PMM_CORE, -1);
      core(1'b1, 1'b0, 14'h0000, PMM_EXT, 2);
      core(1'b1, 1'b1, 14'h1000, PMM_EXT, 1);
      core(1'b1, 1'b0, 14'h2400, PMM_EXT, 0);
      core(1'b1, 1'b1, 14'h3000, PMM_EXT, 3);
      ahb(1'b1, 16'hfff8, 32'h0000_c60a, r);
      ahb(1'b1, 16'hfffc, 32'h0000_0000, r);
      core(1'b0, 1'b0, 14'h0fff, PMM_PROM, -1);
      core(1'b0, 1'b1, 14'h2000, PMM_EXT, 0);
      chk("monitor", 32'h0000_0001, 32'(monitor_avail));
      $display("test 2 done");
      do_reset(1'b1, 1'b0);
      chk("boot load", 32'h0000_0000, 32'(boot_load_en));
      ahb(1'b0, 16'hfff8, 32'h0000_0000, r);
      chk("wait ctl", 32'h0000_7fff, r);
      core(1'b0, 1'b0, 14'h3800, PMM_PRAM, -1);
      core(1'b0, 1'b0, 14'h0000, PMM_EXT, 7);
      $display("test 3 done");
      do_reset(1'b1, 1'b1);
      chk("start addr", 32'h0000_0800, 32'(boot_start_addr));
      ahb(1'b0, 16'hfff8, 32'h0000_0000, r);
      chk("wait ctl", 32'h0000_ffff, r);
      core(1'b0, 1'b0, 14'h0800, PMM_PROM, -1);
      $display("test 4 done");
      ahb(1'b1, 16'hffcc, 32'h0000_4123, r);
      ahb(1'b0, 16'hffcc, 32'h0000_0000, r);
      chk("clock gate reg", 32'h0000_4123, r);
      repeat (3) @(posedge hclk);
      chk("periph clock", 32'h0000_0000, 32'(periph_clk_en));
      chk("clock out", 32'h0000_0000, 32'(instruction_clock_output));
      ahb(1'b1, 16'hffcc, 32'h0000_0123, r);
      repeat (3) @(posedge hclk);
      r = 32'(instruction_clock_output);
      @(posedge hclk);
      chk("clock out", ~r & 32'h0000_0001, 32'(instruction_clock_output));
      chk("periph clock", 32'h0000_0001, 32'(periph_clk_en));
      $display("test 5 done");
      stop_test();
   end
endmodule
